/* File: verilog/i2c_rx_regs.vh */
// constants for the i2c receive and flag block
// assumes inclusion by bare name from verilog/ sources
`ifndef I2C_RX_REGS_VH
`define I2C_RX_REGS_VH

// bits per data byte and the counter value of the acknowledge slot
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT_CNT 4'h9
// count of bits already sampled while the seventh bit is on the wire
`define BIT7_WINDOW_CNT 4'h6
// cpu cycles after an interrupt request during which it must not vanish
`define IRQ_GUARD_CYCLES 3'h6
// reset values
`define BYTE_RESET 8'h00
`define CNT_RESET 4'h0

`endif

/* File: verilog/pin_sync2.v */
// two-stage synchroniser for pin levels
// assumes inputs are asynchronous to clk; outputs are clk-domain levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter WIDTH = 2
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // first stage is read only by the second stage
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // idle i2c lines are high, so reset to ones to avoid false edges
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // pin_sync2

`default_nettype wire

/* File: verilog/i2c_rx_flag_handling.v */
// i2c receive path with double buffering and bus-event flags
// assumes scl/sda pins asynchronous to ref_clk; cpu strobes on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_regs.vh"

module i2c_rx_flag_handling #(
    parameter WINDOW_ABORT = 1
) (
    input wire ref_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire scl_out,
    output wire scl_oe,
    output wire sda_out,
    output wire sda_oe,
    input wire master_mode,
    input wire tx_mode,
    input wire tx_flag_set,
    input wire clr_tx,
    input wire clr_stop,
    input wire clr_start,
    input wire clr_nack,
    input wire rx_read,
    input wire ie_tx,
    input wire ie_stop,
    input wire ie_start,
    input wire ie_nack,
    input wire ie_rx,
    input wire irq_ack,
    output wire [7:0] receive_buffer_reg,
    output wire rx_ready_flag,
    output wire tx_ready_flag,
    output wire stop_seen_flag,
    output wire start_seen_flag,
    output wire nack_seen_flag,
    output wire rx_error_flag,
    output wire scl_held_low_indicator,
    output wire irq,
    output wire irq_spurious
);

    // ==========================================================
    // states
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_SHIFT = 5'b00010;
    localparam [4:0] ST_ACK = 5'b00100;
    localparam [4:0] ST_STALL = 5'b01000;
    localparam [4:0] ST_ABORT = 5'b10000;

    // ==========================================================
    // pin sampling and bus events
    wire [1:0] pins_s;
    wire scl_s;
    wire sda_s;
    reg scl_d_ff;
    reg sda_d_ff;

    pin_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ==========================================================
    // receive state machine
    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [3:0] bitcnt_ff;
    reg [3:0] nxt_bitcnt;
    reg [7:0] shift_ff;
    reg [7:0] nxt_shift;
    reg [7:0] rxbuf_ff;
    reg [7:0] nxt_rxbuf;
    reg rx_full_ff;
    reg rx_err_ff;
    reg load_buf;
    reg collide;
    reg nack_ev;

    always @*
    begin
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_shift = shift_ff;
        nxt_rxbuf = rxbuf_ff;
        load_buf = 1'b0;
        collide = 1'b0;
        nack_ev = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_bitcnt = `CNT_RESET;
            end
            ST_SHIFT:
            begin
                // a read that empties the buffer during bit seven upsets the core
                if (WINDOW_ABORT != 0 && !tx_mode && rx_read && rx_full_ff &&
                    bitcnt_ff == `BIT7_WINDOW_CNT)
                begin
                    collide = 1'b1;
                    nxt_state = master_mode ? ST_IDLE : ST_ABORT;
                end
                else if (scl_rise && bitcnt_ff < `BITS_PER_BYTE)
                begin
                    nxt_shift = {shift_ff[6:0], sda_s};
                    nxt_bitcnt = bitcnt_ff + 4'h1;
                end
                else if (tx_mode && scl_rise && bitcnt_ff == `BITS_PER_BYTE)
                begin
                    nack_ev = sda_s;
                    nxt_bitcnt = `ACK_SLOT_CNT;
                end
                else if (tx_mode && scl_fall && bitcnt_ff == `ACK_SLOT_CNT)
                begin
                    nxt_bitcnt = `CNT_RESET;
                end
                else if (!tx_mode && scl_fall && bitcnt_ff == `BITS_PER_BYTE)
                begin
                    // buffer free (or being read now): move byte, then ack
                    if (!rx_full_ff || rx_read)
                    begin
                        load_buf = 1'b1;
                        nxt_rxbuf = shift_ff;
                        nxt_state = ST_ACK;
                    end
                    else
                    begin
                        nxt_state = ST_STALL;
                    end
                end
            end
            ST_STALL:
            begin
                if (rx_read)
                begin
                    load_buf = 1'b1;
                    nxt_rxbuf = shift_ff;
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    nxt_bitcnt = `CNT_RESET;
                    nxt_state = ST_SHIFT;
                end
            end
            ST_ABORT:
            begin
                // slave leaves sda released in the ack slot, which is a nack
                if (scl_fall && bitcnt_ff == `ACK_SLOT_CNT)
                    nxt_state = ST_IDLE;
                else if (scl_rise && bitcnt_ff < `ACK_SLOT_CNT)
                    nxt_bitcnt = bitcnt_ff + 4'h1;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (start_ev)
        begin
            nxt_state = ST_SHIFT;
            nxt_bitcnt = `CNT_RESET;
        end
        else if (stop_ev)
        begin
            nxt_state = ST_IDLE;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            bitcnt_ff <= `CNT_RESET;
            shift_ff <= `BYTE_RESET;
            rxbuf_ff <= `BYTE_RESET;
            rx_full_ff <= 1'b0;
            rx_err_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff <= nxt_shift;
            rxbuf_ff <= nxt_rxbuf;
            // load wins over a read in the same cycle
            rx_full_ff <= load_buf | (rx_full_ff & ~rx_read);
            // byte in flight is lost; cleared by the next start
            rx_err_ff <= collide | (rx_err_ff & ~start_ev);
        end
    end

    // ==========================================================
    // event flags
    reg tx_flag_ff;
    reg stop_flag_ff;
    reg start_flag_ff;
    reg nack_flag_ff;
    reg nack_pend_ff;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tx_flag_ff <= 1'b0;
            stop_flag_ff <= 1'b0;
            start_flag_ff <= 1'b0;
            nack_flag_ff <= 1'b0;
            nack_pend_ff <= 1'b0;
        end
        else
        begin
            nack_pend_ff <= nack_ev | (nack_pend_ff & ~scl_fall);
            tx_flag_ff <= tx_flag_set |
                (tx_flag_ff & ~clr_tx & ~(nack_pend_ff & scl_fall));
            stop_flag_ff <= stop_ev | (stop_flag_ff & ~clr_stop & ~start_ev);
            start_flag_ff <= start_ev | (start_flag_ff & ~clr_start);
            nack_flag_ff <= nack_ev | (nack_flag_ff & ~clr_nack & ~start_ev);
        end
    end

    // ==========================================================
    // interrupt request with entry guard
    // once raised the request stays up for the guard time, so a flag
    // auto-cleared meanwhile cannot yank it mid-entry; the cpu instead
    // sees irq_spurious and returns without acting
    wire irq_src = (tx_flag_ff & ie_tx) | (stop_flag_ff & ie_stop) |
        (start_flag_ff & ie_start) | (nack_flag_ff & ie_nack) |
        (rx_full_ff & ie_rx);
    reg irq_src_d_ff;
    reg [2:0] guard_ff;
    reg spurious_ff;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq_src_d_ff <= 1'b0;
            guard_ff <= 3'h0;
            spurious_ff <= 1'b0;
        end
        else
        begin
            irq_src_d_ff <= irq_src;
            if (irq_src & ~irq_src_d_ff)
                guard_ff <= `IRQ_GUARD_CYCLES;
            else if (guard_ff != 3'h0)
                guard_ff <= guard_ff - 3'h1;
            // flag vanished while request was guarded
            if (~irq_src & irq_src_d_ff & (guard_ff != 3'h0))
                spurious_ff <= 1'b1;
            else if (irq_ack)
                spurious_ff <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    assign irq = irq_src | (guard_ff != 3'h0);
    assign irq_spurious = spurious_ff;
    assign scl_out = 1'b0;
    assign scl_oe = (state_ff == ST_STALL);
    assign sda_out = 1'b0;
    // ack must stand through the ninth clock high phase; scl fall ends ST_ACK
    assign sda_oe = (state_ff == ST_ACK);
    assign receive_buffer_reg = rxbuf_ff;
    assign rx_ready_flag = rx_full_ff;
    assign tx_ready_flag = tx_flag_ff;
    assign stop_seen_flag = stop_flag_ff;
    assign start_seen_flag = start_flag_ff;
    assign nack_seen_flag = nack_flag_ff;
    assign rx_error_flag = rx_err_ff;
    assign scl_held_low_indicator = ~scl_s;

endmodule // i2c_rx_flag_handling

`default_nettype wire

/* File: dv/i2c_rx_flag_handling_props.sv */
// assertions for the i2c receive and flag block
// assumes one ref_clk domain and the top module's port names
`timescale 1ns/1ps
`default_nettype none

module i2c_rx_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic rx_read,
    input wire logic clr_tx,
    input wire logic clr_stop,
    input wire logic clr_nack,
    input wire logic irq_ack,
    input wire logic irq,
    input wire logic irq_spurious,
    input wire logic rx_ready_flag,
    input wire logic rx_error_flag,
    input wire logic scl_held_low_indicator,
    input wire logic tx_ready_flag,
    input wire logic stop_seen_flag,
    input wire logic start_seen_flag,
    input wire logic nack_seen_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ====
    // properties
    AST_RX_HOLD: assert property (rx_ready_flag && !rx_read |=> rx_ready_flag)
        else $error("rx flag lost without a read");
    AST_ACK_LOAD: assert property ($rose(rx_ready_flag) |-> ##[0:3] sda_oe)
        else $error("loaded byte not acknowledged");
    AST_ERR_CAUSE: assert property ($rose(rx_error_flag) |-> $past(rx_read))
        else $error("receive error without a buffer read");
    // five cycles: two sync stages plus slack for a pin change right at an edge
    AST_SCL_LOW: assert property ((!scl_in) [*5] |-> scl_held_low_indicator)
        else $error("scl low not reported");
    AST_TX_CLR: assert property ($fell(tx_ready_flag) |->
        $past(clr_tx) || $past(nack_seen_flag))
        else $error("tx flag cleared without cause");
    AST_STOP_CLR: assert property ($fell(stop_seen_flag) && !$past(clr_stop) |->
        ##[0:1] start_seen_flag)
        else $error("stop flag cleared without start");
    AST_NACK_CLR: assert property ($fell(nack_seen_flag) && !$past(clr_nack) |->
        ##[0:1] start_seen_flag)
        else $error("nack flag cleared without start");
    AST_IRQ_GUARD: assert property ($rose(irq) |-> irq [*6])
        else $error("interrupt request withdrawn too early");
    AST_SPUR_HOLD: assert property (irq_spurious && !irq_ack |=> irq_spurious)
        else $error("spurious mark lost before entry");
    COV_ERR: cover property ($rose(rx_error_flag));
    COV_STALL: cover property (scl_oe [*8]);
    COV_SPUR: cover property ($rose(irq_spurious));
endmodule // i2c_rx_props

bind i2c_rx_flag_handling i2c_rx_props props (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe),
    .rx_read(rx_read),
    .clr_tx(clr_tx),
    .clr_stop(clr_stop),
    .clr_nack(clr_nack),
    .irq_ack(irq_ack),
    .irq(irq),
    .irq_spurious(irq_spurious),
    .rx_ready_flag(rx_ready_flag),
    .rx_error_flag(rx_error_flag),
    .scl_held_low_indicator(scl_held_low_indicator),
    .tx_ready_flag(tx_ready_flag),
    .stop_seen_flag(stop_seen_flag),
    .start_seen_flag(start_seen_flag),
    .nack_seen_flag(nack_seen_flag)
);
`default_nettype wire

/* File: dv/i2c_bus_master_model.sv */
// behavioural i2c bus master that clocks bytes into the device
// assumes the bench resolves open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_master_model (
    output logic scl_drv,
    output logic sda_drv,
    input wire logic scl,
    input wire logic sda
);
    // ====
    // bus phases, quarter of a 125 ns link period; scl idles outside frames
    localparam realtime Q = 31.25;
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        sda_drv = 1'b1;
        #Q scl_drv = 1'b1;
        #(2*Q) sda_drv = 1'b0;
        #Q scl_drv = 1'b0;
    endtask
    // waits on scl so a stretching device stalls the master
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #Q scl_drv = 1'b1;
        wait (scl);
        #Q s = sda;
        #Q scl_drv = 1'b0;
        #Q;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #Q scl_drv = 1'b1;
        wait (scl);
        #Q sda_drv = 1'b1;
        #Q;
    endtask
endmodule // i2c_bus_master_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the i2c receive and flag block
// assumes the bus master model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic master_mode = 1'b0;
    logic tx_mode = 1'b0;
    logic ie_start = 1'b0;
    logic [6:0] pul = 7'h00;
    logic scl_oe, sda_oe, m_scl, m_sda, ack, rx_f, tx_f, stp_f, stt_f, nck_f;
    logic err_f, low_f, irq, spur;
    logic [7:0] buf_q;
    wire scl = m_scl & ~scl_oe;
    wire sda = m_sda & ~sda_oe;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'h8181, 16'h5a5a};

    i2c_bus_master_model m (.scl_drv(m_scl), .sda_drv(m_sda), .scl(scl), .sda(sda));
    i2c_rx_flag_handling DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .scl_out(),
        .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .master_mode(master_mode),
        .tx_mode(tx_mode), .tx_flag_set(pul[4]), .clr_tx(pul[0]), .clr_stop(pul[1]),
        .clr_start(pul[2]), .clr_nack(pul[3]), .rx_read(pul[5]), .ie_tx(1'b0),
        .ie_stop(1'b0), .ie_start(ie_start), .ie_nack(1'b0), .ie_rx(1'b0),
        .irq_ack(pul[6]), .receive_buffer_reg(buf_q), .rx_ready_flag(rx_f),
        .tx_ready_flag(tx_f), .stop_seen_flag(stp_f), .start_seen_flag(stt_f),
        .nack_seen_flag(nck_f), .rx_error_flag(err_f), .scl_held_low_indicator(low_f),
        .irq(irq), .irq_spurious(spur)
    );
    // ====
    // helpers
    always #2 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // pul bits: 0 clr tx, 1 clr stop, 2 clr start, 3 clr nack, 4 tx set, 5 read, 6 irq ack
    task automatic pulse(input logic [6:0] p);
        @(posedge ref_clk);
        pul <= p;
        @(posedge ref_clk);
        pul <= 7'h00;
        #1;
    endtask
    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            test_done();
        end
    end
    // ====
    // sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk({rx_f, tx_f, stp_f, stt_f, nck_f, err_f, irq, spur}, 8'h00);
        chk(buf_q, 8'h00);
        foreach (rows[i])
        begin
            m.start();
            m.send(rows[i][15:8], ack);
            chk({ack, rx_f, err_f}, 8'h02);
            chk(buf_q, rows[i][7:0]);
            // prompt read on the ready flag, well clear of bit seven
            pulse(7'h20);
            chk({rx_f, err_f}, 8'h00);
        end
        m.stop();
        @(posedge ref_clk) tx_mode <= 1'b1;
        pulse(7'h14);
        m.start();
        chk({stp_f, stt_f, tx_f}, 8'h03);
        m.send(8'hff, ack);
        chk({nck_f, tx_f}, 8'h02);
        @(posedge ref_clk) tx_mode <= 1'b0;
        // nack flag is only polled, so its auto-clear meets no interrupt entry
        m.start();
        chk(nck_f, 8'h00);
        m.send(8'h3c, ack);
        // second byte finds the buffer full, so scl is held until the read
        fork
            m.send(8'hc3, ack);
            begin
                n = 0;
                while (n < 100)
                begin
                    @(posedge ref_clk);
                    #1;
                    n = low_f ? n + 1 : 0;
                end
                chk({low_f, scl}, 8'h02);
                chk(buf_q, 8'h3c);
                pulse(7'h20);
            end
        join
        chk(ack, 8'h00);
        chk(buf_q, 8'hc3);
        pulse(7'h20);
        chk(rx_f, 8'h00);
        for (int mm = 0; mm < 2; mm++)
        begin
            @(posedge ref_clk) master_mode <= mm[0];
            m.start();
            m.send(8'h96, ack);
            fork
                m.send(8'h69, ack);
                begin
                    repeat (6) @(posedge scl);
                    @(negedge scl);
                    pulse(7'h20);
                end
            join
            chk({err_f, ack, rx_f}, 8'h06);
        end
        pulse(7'h04);
        @(posedge ref_clk) ie_start <= 1'b1;
        fork
            m.start();
            begin
                @(posedge ref_clk iff irq);
                pulse(7'h04);
            end
        join
        chk({irq, spur, err_f}, 8'h06);
        pulse(7'h40);
        chk(spur, 8'h00);
        m.stop();
        pulse(7'h0b);
        chk({tx_f, stp_f, nck_f}, 8'h00);
        // second reset with flags and the request up must wipe them all
        m.start();
        m.stop();
        chk({stp_f, stt_f, irq}, 8'h07);
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk({rx_f, tx_f, stp_f, stt_f, nck_f, err_f, irq, spur}, 8'h00);
        test_done();
    end
endmodule // testbench
`default_nettype wire
